// >>> rtl/crg_pkg.sv
// constants shared by the clock request gating block
package crg_pkg;
	localparam int CRG_CHANNELS = 4;
	localparam int CRG_AW = 3;
	localparam int CRG_DW = 8;

	// register offsets
	localparam logic [2:0] CRG_OFS_POLARITY = 3'h0;
	localparam logic [2:0] CRG_OFS_SOFT = 3'h1;
	localparam logic [2:0] CRG_OFS_PRIORITY = 3'h2;
	localparam logic [2:0] CRG_OFS_DRIVE = 3'h3;
	localparam logic [2:0] CRG_OFS_STATUS = 3'h4;

	// field positions
	localparam int CRG_POL_LSB = 0;
	localparam int CRG_SOFT_LSB = 0;
	localparam int CRG_UPMODE_LSB = 4;
	localparam int CRG_PRIO_LSB = 0;
	localparam int CRG_REGOVR_LSB = 4;
	localparam int CRG_DRIVE_LSB = 4;

	// reset values after core power-up, and the mask of channels forced on while the reset pin holds
	localparam logic [3:0] CRG_POL_RST = 4'h0;
	localparam logic [3:0] CRG_SOFT_RST = 4'h9;
	localparam logic [3:0] CRG_PRIO_RST = 4'h9;
	localparam logic [3:0] CRG_FORCED_MASK = 4'h9;
	localparam logic [1:0] CRG_UPMODE_RST = 2'h0;
	localparam logic [1:0] CRG_REGOVR_RST = 2'h0;
	localparam logic [3:0] CRG_DRIVE_RST = 4'h0;

	// upstream request drive modes
	typedef enum logic [1:0] {
		CRG_UP_WIRED_OR = 2'b00,
		CRG_UP_PUSH_PULL = 2'b01,
		CRG_UP_WIRED_AND = 2'b10
	} crg_upmode_t;

	// regulator override settings
	typedef enum logic [1:0] {
		CRG_REG_DECODER = 2'b00,
		CRG_REG_FORCE_OFF = 2'b01,
		CRG_REG_FORCE_ON = 2'b10
	} crg_regovr_t;

	// timing
	localparam int CRG_CLK_PERIOD_NS = 10;
	localparam int CRG_FILTER_NS = 300;
	localparam int CRG_MIN_PULSE_NS = 500;
	localparam int CRG_FILTER_CYCLES_RAW = CRG_FILTER_NS / CRG_CLK_PERIOD_NS;
	localparam int CRG_FILTER_CYCLES = (CRG_FILTER_CYCLES_RAW < 1) ? 1 : CRG_FILTER_CYCLES_RAW;
	localparam int CRG_FILTER_W = 6;
endpackage

// >>> rtl/crg_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module crg_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stable_r;

	// first stage feeds only the second stage
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			meta_r <= RST_VAL;
			stable_r <= RST_VAL;
		end else begin
			meta_r <= async_i;
			stable_r <= meta_r;
		end
	end

	assign sync_o = stable_r;
endmodule
`default_nettype wire

// >>> rtl/crg_reset_filter.sv
// glitch filter for the active-low reset pin
`timescale 1ns/1ps
`default_nettype none
module crg_reset_filter
	import crg_pkg::*;
#(
	parameter int FILTER_CYCLES = CRG_FILTER_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic pin_low_i,
	output logic reset_active_o
);
	localparam logic [CRG_FILTER_W-1:0] LIMIT = CRG_FILTER_W'(FILTER_CYCLES);
	logic [CRG_FILTER_W-1:0] count_r;
	logic [CRG_FILTER_W-1:0] count_nxt;
	logic active_r;
	wire reached = (count_r >= LIMIT);

	// any high sample restarts the count, so short spikes never assert
	assign count_nxt = !pin_low_i ? '0 : (reached ? count_r : count_r + 1'b1);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			count_r <= '0;
			active_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			active_r <= pin_low_i && reached;
		end
	end

	assign reset_active_o = active_r;
endmodule
`default_nettype wire

// >>> rtl/crg_top.sv
// clock request gating: channel decode, regulator and upstream request control
`timescale 1ns/1ps
`default_nettype none
module crg_top
	import crg_pkg::*;
#(
	parameter int CHANNELS = CRG_CHANNELS,
	parameter int FILTER_CYCLES = CRG_FILTER_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [CHANNELS-1:0] peripheral_demand_line_i,
	input wire logic reset_n_i,
	input wire logic master_clk_i,
	input wire logic battery_supply_i,
	input wire logic core_supply_i,
	input wire logic analog_supply_i,
	input wire logic [CRG_AW-1:0] reg_addr_i,
	input wire logic [CRG_DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [CRG_DW-1:0] reg_rdata_o,
	output logic [CHANNELS-1:0] buffered_clock_output_o,
	output logic [CHANNELS-1:0] buffered_clock_output_oe_n_o,
	output logic upstream_req_o,
	output logic upstream_req_oe_n_o,
	output logic tcxo_regulator_en_o,
	output logic [3:0] drive_strength_o
);
	// synchronised inputs
	logic [CHANNELS-1:0] demand_sync;
	logic reset_pin_sync;
	logic reset_active;

	// software settings
	logic [3:0] polarity_r;
	logic [3:0] soft_demand_r;
	logic [3:0] priority_r;
	logic [1:0] upmode_r;
	logic [1:0] regovr_r;
	logic [3:0] drive_r;

	// gating state
	logic [CHANNELS-1:0] chan_on_r;
	logic [CHANNELS-1:0] chan_demand;
	logic upstream_r;
	logic regulator_r;
	logic reset_seen_r;
	logic [CRG_DW-1:0] rdata_r;

	crg_sync #(
		.WIDTH(CHANNELS),
		.RST_VAL('0)
	) u_demand_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.async_i(peripheral_demand_line_i),
		.sync_o(demand_sync)
	);

	crg_sync #(
		.WIDTH(1),
		.RST_VAL(1'b1)
	) u_reset_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.async_i(reset_n_i),
		.sync_o(reset_pin_sync)
	);

	crg_reset_filter #(
		.FILTER_CYCLES(FILTER_CYCLES)
	) u_reset_filter (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_low_i(!reset_pin_sync),
		.reset_active_o(reset_active)
	);

	// register decode; nothing is taken while the reset pin holds
	wire access_ok = !reset_active;
	wire wr_ok = reg_wr_i && access_ok;
	wire rd_ok = reg_rd_i && access_ok;
	wire wr_pol = wr_ok && (reg_addr_i == CRG_OFS_POLARITY);
	wire wr_soft = wr_ok && (reg_addr_i == CRG_OFS_SOFT);
	wire wr_prio = wr_ok && (reg_addr_i == CRG_OFS_PRIORITY);
	wire wr_drive = wr_ok && (reg_addr_i == CRG_OFS_DRIVE);

	// edge of the filtered reset: restore only channels 1 and 4
	wire reset_rise = reset_active && !reset_seen_r;
	wire [3:0] keep_mask = ~CRG_FORCED_MASK;

	// next values of the software settings
	logic [3:0] polarity_nxt;
	logic [3:0] soft_nxt;
	logic [3:0] prio_nxt;
	logic [1:0] upmode_nxt;
	logic [1:0] regovr_nxt;
	logic [3:0] drive_nxt;

	assign polarity_nxt = wr_pol ? reg_wdata_i[CRG_POL_LSB +: 4] : polarity_r;

	assign upmode_nxt = wr_soft ? reg_wdata_i[CRG_UPMODE_LSB +: 2] : upmode_r;

	assign soft_nxt = reset_rise
		? ((soft_demand_r & keep_mask) | (CRG_SOFT_RST & CRG_FORCED_MASK))
		: (wr_soft ? reg_wdata_i[CRG_SOFT_LSB +: 4] : soft_demand_r);

	assign prio_nxt = reset_rise
		? ((priority_r & keep_mask) | (CRG_PRIO_RST & CRG_FORCED_MASK))
		: (wr_prio ? reg_wdata_i[CRG_PRIO_LSB +: 4] : priority_r);

	assign regovr_nxt = wr_prio ? reg_wdata_i[CRG_REGOVR_LSB +: 2] : regovr_r;

	assign drive_nxt = wr_drive ? reg_wdata_i[CRG_DRIVE_LSB +: 4] : drive_r;

	// core power-up brings every setting to its default
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			polarity_r <= CRG_POL_RST;
			soft_demand_r <= CRG_SOFT_RST;
			priority_r <= CRG_PRIO_RST;
			upmode_r <= CRG_UPMODE_RST;
			regovr_r <= CRG_REGOVR_RST;
			drive_r <= CRG_DRIVE_RST;
			reset_seen_r <= 1'b0;
		end else begin
			polarity_r <= polarity_nxt;
			soft_demand_r <= soft_nxt;
			priority_r <= prio_nxt;
			upmode_r <= upmode_nxt;
			regovr_r <= regovr_nxt;
			drive_r <= drive_nxt;
			reset_seen_r <= reset_active;
		end
	end

	// per-channel demand decode
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
			// polarity bit set means the pin is active low
			wire pin_active = demand_sync[gi] ^ polarity_r[gi];
			wire src_active = priority_r[gi] ? soft_demand_r[gi] : pin_active;
			wire forced = reset_active && CRG_FORCED_MASK[gi];
			assign chan_demand[gi] = src_active || forced;
		end
	endgenerate

	wire any_demand = |chan_demand;
	wire supplies_ok = battery_supply_i && core_supply_i;

	// decoder result, then software override
	logic reg_want;
	assign reg_want = (regovr_r == CRG_REG_FORCE_ON) ? 1'b1
		: (regovr_r == CRG_REG_FORCE_OFF) ? 1'b0
		: (any_demand || reset_active);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			chan_on_r <= '0;
			upstream_r <= 1'b0;
			regulator_r <= 1'b0;
		end else begin
			chan_on_r <= chan_demand;
			upstream_r <= any_demand;
			regulator_r <= supplies_ok && reg_want;
		end
	end

	// clock gating: a disabled channel sits at high level, not low
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_out
			assign buffered_clock_output_o[gi] = chan_on_r[gi] ? master_clk_i : 1'b1;
			// without the analog supply the buffers float
			assign buffered_clock_output_oe_n_o[gi] = !analog_supply_i;
		end
	endgenerate

	// upstream request pin drive by mode
	logic up_level;
	logic up_oe_n;
	always_comb begin
		up_level = upstream_r;
		up_oe_n = 1'b1;
		case (crg_upmode_t'(upmode_r))
			CRG_UP_WIRED_OR: begin
				// open source: drive high only, external pulldown idles it
				up_level = 1'b1;
				up_oe_n = !upstream_r;
			end
			CRG_UP_PUSH_PULL: begin
				up_level = upstream_r;
				up_oe_n = 1'b0;
			end
			CRG_UP_WIRED_AND: begin
				// open drain: drive low only while idle
				up_level = 1'b0;
				up_oe_n = upstream_r;
			end
			default: begin
				up_level = 1'b1;
				up_oe_n = !upstream_r;
			end
		endcase
	end

	assign upstream_req_o = up_level;
	assign upstream_req_oe_n_o = up_oe_n;
	assign tcxo_regulator_en_o = regulator_r;
	assign drive_strength_o = drive_r;

	// read mux; unmapped offsets and refused reads give zero
	logic [CRG_DW-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (reg_addr_i)
			CRG_OFS_POLARITY: rd_mux = {4'h0, polarity_r};
			CRG_OFS_SOFT: rd_mux = {2'h0, upmode_r, soft_demand_r};
			CRG_OFS_PRIORITY: rd_mux = {2'h0, regovr_r, priority_r};
			CRG_OFS_DRIVE: rd_mux = {drive_r, 4'h0};
			CRG_OFS_STATUS: rd_mux = {upstream_r, regulator_r, reset_active,
				1'b0, chan_on_r};
			default: rd_mux = '0;
		endcase
	end

	// read data stand for exactly one cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rd_ok ? rd_mux : '0;
		end
	end

	assign reg_rdata_o = rdata_r;
endmodule
`default_nettype wire

// >>> testbench/crg_props.sv
// assertion checker for the clock request gating top
`timescale 1ns/1ps
`default_nettype none
module crg_props #(
	parameter int FILTER_CYCLES = 3
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic reset_n_i,
	input wire logic master_clk_i,
	input wire logic battery_supply_i,
	input wire logic core_supply_i,
	input wire logic analog_supply_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [3:0] buffered_clock_output_o,
	input wire logic [3:0] buffered_clock_output_oe_n_o,
	input wire logic tcxo_regulator_en_o,
	input wire logic [3:0] drive_strength_o
);
	logic [7:0] low_cnt_r;
	// saturates so that a long hold on the reset pin stays flagged
	always_ff @(posedge clock_i) begin
		if (rst_i || reset_n_i) begin
			low_cnt_r <= 8'h00;
		end else if (low_cnt_r != 8'hff) begin
			low_cnt_r <= low_cnt_r + 8'h01;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	AST_HIZ: assert property (buffered_clock_output_oe_n_o == {4{!analog_supply_i}})
		else $error("clock output enables disagree with analog supply");
	AST_IDLE_HIGH: assert property (master_clk_i |-> buffered_clock_output_o == 4'hf)
		else $error("clock output low while master clock high");
	AST_REG_SUPPLY: assert property (!$past(battery_supply_i && core_supply_i)
		|-> !tcxo_regulator_en_o)
		else $error("regulator on without both supplies");
	AST_LOCKED: assert property ((low_cnt_r > FILTER_CYCLES + 5 && reg_rd_i) |=> reg_rdata_o == 8'h00)
		else $error("register read answered during reset");
	AST_FORCED: assert property (low_cnt_r > FILTER_CYCLES + 6
		|-> buffered_clock_output_o[0] == master_clk_i
		&& buffered_clock_output_o[3] == master_clk_i)
		else $error("outputs 1 and 4 not forced on during reset");
	AST_POWERUP: assert property (disable iff (1'b0) rst_i |=> !tcxo_regulator_en_o
		&& reg_rdata_o == 8'h00 && drive_strength_o == 4'h0)
		else $error("power-up reset left outputs set");
	AST_DRIVE: assert property ($changed(drive_strength_o) && !$past(rst_i)
		|-> $past(reg_wr_i) && $past(reg_addr_i) == 3'h3
		&& drive_strength_o == ($past(reg_wdata_i) >> 4))
		else $error("drive field changed without its write");
	AST_BOOT_ON: assert property ($fell(rst_i) |=> buffered_clock_output_o[0] == master_clk_i && buffered_clock_output_o[3] == master_clk_i)
		else $error("outputs 1 and 4 not on after power-up");
	COV_STATUS: cover property (reg_rd_i && reg_addr_i == 3'h4);
	COV_LONG_RESET: cover property (low_cnt_r > FILTER_CYCLES + 6);
	COV_DRIVE_WR: cover property (reg_wr_i && reg_addr_i == 3'h3);
endmodule
bind crg_top crg_props #(.FILTER_CYCLES(FILTER_CYCLES)) u_props (.*);
`default_nettype wire

// >>> testbench/crg_periph_model.sv
// peripherals raising clock requests and the free-running master clock source
`timescale 1ns/1ps
`default_nettype none
module crg_periph_model (
	input wire logic clock_i,
	input wire logic [3:0] want_i,
	output logic [3:0] demand_o,
	output logic mclk_o
);
	initial mclk_o = 1'b0;
	initial demand_o = 4'h0;
	// period unrelated to clock_i so the gate is seen at many phases
	always #7 mclk_o = ~mclk_o;
	// peripherals change their request lines on the rising edge of clock_i, the sampling edge
	always @(posedge clock_i) demand_o <= want_i;
endmodule
`default_nettype wire

// >>> testbench/clock_request_gating_bench.sv
// self-checking bench for the clock request gating top
`timescale 1ns/1ps
`default_nettype none
module clock_request_gating_bench;
	import crg_pkg::*;
	logic clk = 1'b0, rst = 1'b1, rst_n = 1'b1, batt = 1'b1, core = 1'b1, ana = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, up, up_oe_n, reg_en, mclk;
	logic [3:0] want = 4'h0, dem, bco, bco_oe_n, drive;
	logic [31:0] lfsr = 32'he88e;
	logic [7:0] m3;
	int fails = 0, num_checks = 0;
	localparam logic [7:0] MASK [4] = '{8'h0f, 8'h3f, 8'h3f, 8'hf0};
	localparam logic [7:0] DEF [4] = '{8'h00, 8'h09, 8'h09, 8'h00};
	always #5 clk = ~clk;
	crg_periph_model u_periph (.clock_i(clk), .want_i(want), .demand_o(dem), .mclk_o(mclk));
	crg_top #(.FILTER_CYCLES(3)) uut (.clock_i(clk), .rst_i(rst), .peripheral_demand_line_i(dem),
		.reset_n_i(rst_n), .master_clk_i(mclk), .battery_supply_i(batt), .core_supply_i(core),
		.analog_supply_i(ana), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(rdata), .buffered_clock_output_o(bco),
		.buffered_clock_output_oe_n_o(bco_oe_n), .upstream_req_o(up),
		.upstream_req_oe_n_o(up_oe_n), .tcxo_regulator_en_o(reg_en), .drive_strength_o(drive));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic put_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic get_reg(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", e, rdata);
	endtask
	task automatic defaults();
		for (int i = 0; i < 4; i++) get_reg(i[2:0], DEF[i]);
		get_reg(3'h5, 8'h00);
		chk("drive", 8'h00, {4'h0, drive});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#300000;
		fails++;
		conclude();
	end
	initial begin
		logic [31:0] r;
		logic [3:0] on;
		logic [1:0] md;
		logic rg;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		defaults();
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			r = lfsr;
			if (r[5:4] == 2'b11) r[5] = 1'b0;
			put_reg(i[2:0], r[7:0]);
			get_reg(i[2:0], r[7:0] & MASK[i]);
			m3 = r[7:0] & MASK[3];
		end
		chk("drive", {4'h0, m3[7:4]}, {4'h0, drive});
		// a second power-up in mid-run must return every setting to its default
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		defaults();
		for (int n = 0; n < 16; n++) begin
			lfsr = nxt(lfsr);
			r = lfsr;
			md = (r[5:4] == 2'b11) ? 2'b00 : r[5:4];
			put_reg(3'h0, {4'h0, r[3:0]});
			put_reg(3'h1, {2'b00, md, r[11:8]});
			put_reg(3'h2, {2'b00, r[13:12], r[19:16]});
			want <= r[27:24];
			batt <= r[28] | r[29];
			core <= r[30] | r[29];
			ana <= r[31];
			repeat (6) @(posedge clk);
			on = (r[19:16] & r[11:8]) | (~r[19:16] & (r[27:24] ^ r[3:0]));
			rg = batt & core & ((r[13:12] == 2'b10) | ((r[13:12] != 2'b01) & (|on)));
			get_reg(3'h4, {|on, rg, 2'b00, on});
			chk("up_oe_n", {7'h0, (md == 2'b01) ? 1'b0 : (md == 2'b10) ? |on : ~|on}, {7'h0, up_oe_n});
			chk("up", {7'h0, (md == 2'b01) ? |on : (md == 2'b10) ? 1'b0 : 1'b1}, {7'h0, up});
			chk("reg_en", {7'h0, rg}, {7'h0, reg_en});
			chk("clk_oe_n", {4'h0, {4{~ana}}}, {4'h0, bco_oe_n});
			@(negedge mclk);
			#1;
			chk("clk_out", {4'h0, ~on}, {4'h0, bco});
		end
		@(posedge clk);
		want <= 4'h0;
		batt <= 1'b1;
		core <= 1'b1;
		ana <= 1'b1;
		put_reg(3'h0, 8'h00);
		put_reg(3'h3, m3);
		put_reg(3'h1, 8'h06);
		put_reg(3'h2, 8'h02);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		get_reg(3'h1, 8'h06);
		@(posedge clk);
		rst_n <= 1'b0;
		// hold the pin low for the full minimum pulse of 50 cycles
		repeat (50) @(posedge clk);
		put_reg(3'h3, ~m3);
		get_reg(3'h4, 8'h00);
		@(negedge mclk);
		#1;
		chk("clk_out", 8'h04, {4'h0, bco});
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		get_reg(3'h1, 8'h0f);
		get_reg(3'h2, 8'h0b);
		get_reg(3'h3, m3);
		conclude();
	end
endmodule
`default_nettype wire
